// ===== adc_link_params.svh
// Shared constants for the serial sample link: frame layout and timing.
// Assumes the local clock runs at CLK_FREQ_KHZ; included by bare name.
`ifndef ADC_LINK_PARAMS_SVH
`define ADC_LINK_PARAMS_SVH

// Frame layout
`define FRAME_BITS 16
`define NULL_BITS 4
`define DATA_BITS 12
`define DATA_MSB_OFS 12'h800

// Local clock rate
`define CLK_FREQ_KHZ 50000

// Serial clock limits while converting
`define SCLK_MIN_FREQ_KHZ 3200
`define SCLK_MAX_FREQ_KHZ 8000

// Least half period at the fastest serial clock, rounded up
`define SCLK_HALF_MIN_CYC \
	((`CLK_FREQ_KHZ + 2 * `SCLK_MAX_FREQ_KHZ - 1) / (2 * `SCLK_MAX_FREQ_KHZ))
// Longest half period at the slowest serial clock, rounded down
`define SCLK_HALF_MAX_CYC (`CLK_FREQ_KHZ / (2 * `SCLK_MIN_FREQ_KHZ))

// Frame repetition limits
`define RATE_MIN_KSPS 200
`define RATE_MAX_KSPS 500
// Least frame period at the highest rate, rounded up
`define FRAME_MIN_CYC \
	((`CLK_FREQ_KHZ + `RATE_MAX_KSPS - 1) / `RATE_MAX_KSPS)
// Longest frame period at the lowest rate, rounded down
`define FRAME_MAX_CYC (`CLK_FREQ_KHZ / `RATE_MIN_KSPS)

`endif

// ===== adc_link_pkg.sv
// Types shared by both ends of the serial sample link.
// Assumes nothing of its surroundings.
package adc_link_pkg;

	// Converter end: asleep or converting
	typedef enum logic [0:0] {
		ST_PDOWN,
		ST_CONV
	} dev_state_e;

	// Controller end: waiting or running a frame
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_FRAME
	} host_state_e;

endpackage

// ===== adc_link_if.sv
// Serial link wires between converter and controller.
// Assumes the data line reads low while the converter does not drive it.
`timescale 1ns/1ns
interface adc_link_if;
	logic cs_n;     // Chip select, active low, from controller
	logic sclk;     // Serial clock, from controller
	logic sdata_o;  // Serial data as driven by converter
	logic sdata_oe; // Converter drives the data line
	logic sdata;    // Resolved data line level

	// Released line is held low by a weak pull
	assign sdata = sdata_oe ? sdata_o : 1'b0;

	modport device (
		input  cs_n,
		input  sclk,
		output sdata_o,
		output sdata_oe
	);

	modport host (
		output cs_n,
		output sclk,
		input  sdata
	);
endinterface

// ===== adc_sample_device.sv
// Converter end of the serial link: captures a differential sample on
// chip select fall and returns it as a 16-bit frame paced by the clock.
// Assumes cs_n and sclk arrive from another domain; vin_p and vin_n are
// steady logic on this clock while a frame starts.
`timescale 1ns/1ns
`include "adc_link_params.svh"

module adc_sample_device
	import adc_link_pkg::*;
#(
	parameter int DATA_W = `DATA_BITS  // Result width
) (
	// Clock, reset and enable
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              ce,
	// Serial link
	adc_link_if.device             link,
	// Differential input codes
	input  wire logic [DATA_W-1:0] vin_p,
	input  wire logic [DATA_W-1:0] vin_n,
	// Status
	output logic                   power_down,
	output logic                   busy
);

	// Synchroniser stages: bit 0 first flop, bit 1 second, bit 2 history
	logic [2:0]        cs_sync_q;
	logic [2:0]        cs_sync_d;
	logic [2:0]        sclk_sync_q;
	logic [2:0]        sclk_sync_d;

	// Converter state
	dev_state_e        state_q;
	dev_state_e        state_d;
	logic [4:0]        rise_cnt_q;  // Rising serial edges seen this frame
	logic [4:0]        rise_cnt_d;
	logic [DATA_W-1:0] samp_q;      // Held sample, offset binary
	logic [DATA_W-1:0] samp_d;
	logic [DATA_W-1:0] sar_q;       // Successive approximation result
	logic [DATA_W-1:0] sar_d;
	logic              dout_q;      // Serial data bit on the line
	logic              dout_d;
	logic              oe_q;        // Line driven
	logic              oe_d;

	// Decoded edges, seen only on second and history stages
	logic              cs_fall;
	logic              cs_high;
	logic              sclk_rise;
	logic              sclk_fall;

	// Working values for the conversion step
	logic [DATA_W:0]   diff;        // Signed difference, one bit wider
	logic [DATA_W-1:0] code;        // Halved difference, two's complement
	logic [DATA_W-1:0] trial;       // Candidate result with trial bit
	logic [3:0]        dec_bit;     // Bit decided on this rising edge
	logic [3:0]        out_bit;     // Frame position sent on this fall

	// Edge detection looks at settled stages only
	assign cs_high   = cs_sync_q[1];
	assign cs_fall   = cs_sync_q[2] & ~cs_sync_q[1];
	assign sclk_rise = ~sclk_sync_q[2] & sclk_sync_q[1];
	assign sclk_fall = sclk_sync_q[2] & ~sclk_sync_q[1];

	// Synchroniser next values
	always_comb begin
		cs_sync_d   = cs_sync_q;
		sclk_sync_d = sclk_sync_q;
		if (ce) begin
			// Shift pins in; the first stage feeds the second only
			cs_sync_d   = {cs_sync_q[1:0], link.cs_n};
			sclk_sync_d = {sclk_sync_q[1:0], link.sclk};
		end
	end

	// Synchroniser registers; select resets high so no false start
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cs_sync_q   <= 3'h7;
			sclk_sync_q <= 3'h0;
		end else begin
			cs_sync_q   <= cs_sync_d;
			sclk_sync_q <= sclk_sync_d;
		end
	end

	// Sample encoding: difference halved keeps range in twelve bits
	always_comb begin
		diff = {1'b0, vin_p} - {1'b0, vin_n};
		// Arithmetic halving of the signed difference
		code = diff[DATA_W:1];
	end

	// Bit positions from the count of rising edges so far
	always_comb begin
		// Rising edge number n decides bit 15 - n, here n = count + 1
		dec_bit = 4'(5'd14 - rise_cnt_q);
		// A fall after n rises sends frame bit 15 - n
		out_bit = 4'(5'd15 - rise_cnt_q);
		trial   = sar_q | (12'h001 << dec_bit);
	end

	// Converter next values
	always_comb begin
		state_d    = state_q;
		rise_cnt_d = rise_cnt_q;
		samp_d     = samp_q;
		sar_d      = sar_q;
		dout_d     = dout_q;
		oe_d       = oe_q;
		if (ce) begin
			case (state_q)
				ST_PDOWN: begin
					// Asleep: line released, nothing steps
					oe_d = 1'b0;
					if (cs_fall) begin
						// Track ends, hold begins on the select fall
						state_d    = ST_CONV;
						rise_cnt_d = 5'h00;
						// Offset binary makes the comparison unsigned
						samp_d     = code ^ `DATA_MSB_OFS;
						sar_d      = '0;
						// First null bit shows before the first rise
						dout_d     = 1'b0;
						oe_d       = 1'b1;
					end
				end
				ST_CONV: begin
					if (cs_high) begin
						// Select high ends the frame, even mid-way
						state_d = ST_PDOWN;
						oe_d    = 1'b0;
						dout_d  = 1'b0;
					end else if (sclk_rise) begin
						// Count rises; extra clocks past the frame idle
						if (rise_cnt_q < 5'(`FRAME_BITS)) begin
							rise_cnt_d = rise_cnt_q + 5'h01;
						end
						// Rises 4 to 15 each settle one result bit
						if (rise_cnt_q >= 5'(`NULL_BITS - 1) &&
						    rise_cnt_q <= 5'(`FRAME_BITS - 2)) begin
							if (trial <= samp_q) begin
								sar_d = trial;
							end
						end
					end else if (sclk_fall) begin
						// New bit only on falls, stable across each rise
						if (rise_cnt_q >= 5'h01 &&
						    rise_cnt_q <= 5'(`FRAME_BITS - 1)) begin
							if (out_bit >= 4'(`DATA_BITS)) begin
								// Leading null bits
								dout_d = 1'b0;
							end else if (out_bit == 4'(`DATA_BITS - 1)) begin
								// Sign bit: inverted offset MSB
								dout_d = ~sar_q[out_bit];
							end else begin
								// Remaining bits, MSB first
								dout_d = sar_q[out_bit];
							end
						end else begin
							// Past the frame the line rests low
							dout_d = 1'b0;
						end
					end
				end
				default: begin
					// Unknown state falls back to sleep
					state_d = ST_PDOWN;
					oe_d    = 1'b0;
				end
			endcase
		end
	end

	// Converter registers
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_q    <= ST_PDOWN;
			rise_cnt_q <= 5'h00;
			samp_q     <= '0;
			sar_q      <= '0;
			dout_q     <= 1'b0;
			oe_q       <= 1'b0;
		end else begin
			state_q    <= state_d;
			rise_cnt_q <= rise_cnt_d;
			samp_q     <= samp_d;
			sar_q      <= sar_d;
			dout_q     <= dout_d;
			oe_q       <= oe_d;
		end
	end

	// Line drive and status straight from flops
	assign link.sdata_o  = dout_q;
	assign link.sdata_oe = oe_q;
	assign power_down    = (state_q == ST_PDOWN);
	assign busy          = (state_q == ST_CONV);

endmodule

// ===== adc_sample_host.sv
// Controller end of the serial link: makes chip select and the serial
// clock from the local clock, collects each frame and queues the result.
// Assumes sdata arrives from another domain and the converter end keeps
// its latency well under one serial half period.
`timescale 1ns/1ns
`include "adc_link_params.svh"

module adc_sample_host
	import adc_link_pkg::*;
#(
	parameter int DATA_W    = `DATA_BITS,          // Result width
	parameter int DEPTH     = 2,                   // Buffer entries
	parameter int HALF_CYC  = `SCLK_HALF_MAX_CYC,  // Serial half period
	parameter int FRAME_CYC = `FRAME_MAX_CYC       // Select fall spacing
) (
	// Clock, reset and enable
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              ce,
	// Frame control
	input  wire logic              run,
	output logic                   frame_active,
	// Serial link
	adc_link_if.host               link,
	// Result stream
	output logic                   rd_valid,
	input  wire logic              rd_ready,
	output logic [DATA_W-1:0]      rd_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Data line synchroniser: bit 0 first flop, bit 1 settled
	logic [1:0]        sd_q;
	logic [1:0]        sd_d;

	// Frame sequencer
	host_state_e       state_q;
	host_state_e       state_d;
	logic [7:0]        half_q;    // Cycles within a half period
	logic [7:0]        half_d;
	logic [5:0]        phase_q;   // Half periods within the frame
	logic [5:0]        phase_d;
	logic [8:0]        period_q;  // Cycles since the last select fall
	logic [8:0]        period_d;
	logic              sclk_q;
	logic              sclk_d;
	logic              cs_n_q;
	logic              cs_n_d;
	logic [15:0]       shift_q;   // Collected frame bits
	logic [15:0]       shift_d;

	// Two-entry buffer
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [DATA_W-1:0] mem_d [DEPTH];
	logic [PW-1:0]     wr_q;
	logic [PW-1:0]     wr_d;
	logic [PW-1:0]     rd_q;
	logic [PW-1:0]     rd_d;
	logic [PW:0]       cnt_q;
	logic [PW:0]       cnt_d;
	logic              push;
	logic              pop;
	logic              full;
	logic              half_end;
	logic [15:0]       word;

	assign full     = (cnt_q == (PW+1)'(DEPTH));
	assign pop      = rd_valid & rd_ready;
	assign half_end = (half_q == 8'(HALF_CYC - 1));
	assign word     = {shift_q[14:0], sd_q[1]};

	// Sequencer next values
	always_comb begin
		sd_d     = sd_q;
		state_d  = state_q;
		half_d   = half_q;
		phase_d  = phase_q;
		period_d = period_q;
		sclk_d   = sclk_q;
		cs_n_d   = cs_n_q;
		shift_d  = shift_q;
		push     = 1'b0;
		if (ce) begin
			sd_d = {sd_q[0], link.sdata};
			// Spacing counter saturates once a new frame may start
			if (period_q < 9'(FRAME_CYC - 1)) begin
				period_d = period_q + 9'h001;
			end
			case (state_q)
				ST_IDLE: begin
					// A full buffer stalls the next frame, so no loss
					if (run && !full &&
					    period_q >= 9'(FRAME_CYC - 1)) begin
						state_d  = ST_FRAME;
						cs_n_d   = 1'b0;
						period_d = 9'h000;
						half_d   = 8'h00;
						phase_d  = 6'h00;
					end
				end
				ST_FRAME: begin
					half_d = half_q + 8'h01;
					if (half_end) begin
						half_d = 8'h00;
						if (phase_q == 6'(2 * `FRAME_BITS)) begin
							// Sixteen clocks done: end frame, sleep
							state_d = ST_IDLE;
							cs_n_d  = 1'b1;
						end else begin
							phase_d = phase_q + 6'h01;
							sclk_d  = ~sclk_q;
							if (!sclk_q) begin
								// Rising edge: take the settled bit
								shift_d = word;
								if (phase_q == 6'(2 * `FRAME_BITS - 2)) begin
									push = 1'b1;
								end
							end
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					cs_n_d  = 1'b1;
					sclk_d  = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sd_q     <= 2'h0;
			state_q  <= ST_IDLE;
			half_q   <= 8'h00;
			phase_q  <= 6'h00;
			period_q <= 9'(FRAME_CYC - 1);
			sclk_q   <= 1'b0;
			cs_n_q   <= 1'b1;
			shift_q  <= 16'h0000;
		end else begin
			sd_q     <= sd_d;
			state_q  <= state_d;
			half_q   <= half_d;
			phase_q  <= phase_d;
			period_q <= period_d;
			sclk_q   <= sclk_d;
			cs_n_q   <= cs_n_d;
			shift_q  <= shift_d;
		end
	end

	// Buffer next values; the null bits are dropped on the way in
	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (ce) begin
			if (push) begin
				mem_d[wr_q] = word[DATA_W-1:0];
				wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
			end
			if (pop) begin
				rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
			end
			cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Buffer registers
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			mem_q <= mem_d;
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Outputs
	assign link.cs_n    = cs_n_q;
	assign link.sclk    = sclk_q;
	assign frame_active = (state_q == ST_FRAME);
	assign rd_valid     = ce & (cnt_q != '0);
	assign rd_data      = mem_q[rd_q];

endmodule

// ===== adc_link_monitor.sv
// Checker for the serial link wires between both ends.
// Assumes it sits beside the interface, on the local clock.
`timescale 1ns/1ns
module adc_link_monitor #(
	parameter int FRAME_CYC = 250  // Least select fall spacing
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdata_o,
	input wire logic sdata_oe,
	input wire logic sdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic [15:0] lo_q, lo_d;     // Select low time
	logic [15:0] gap_q, gap_d;   // Cycles since select fall
	logic [4:0]  ris_q, ris_d;   // Clock rises this frame
	logic        cs_p_q, sck_p_q; // Previous levels
	logic        seen_q, seen_d; // A fall was seen
	// Frame figures; gap saturates so a long idle cannot wrap
	always_comb begin
		lo_d = cs_n ? 16'h0 : lo_q + 16'h1;
		ris_d = cs_n ? 5'h0 : ris_q + {4'h0, sclk & ~sck_p_q};
		gap_d = (gap_q == 16'hffff) ? gap_q : gap_q + 16'h1;
		if (cs_p_q && !cs_n) begin
			gap_d = 16'h1;
		end
		seen_d = seen_q | (cs_p_q & ~cs_n);
	end
	// Registers only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			{lo_q, gap_q, ris_q, seen_q} <= '0;
			cs_p_q <= 1'b1;
			sck_p_q <= 1'b0;
		end else begin
			{lo_q, gap_q, ris_q, seen_q} <= {lo_d, gap_d, ris_d, seen_d};
			cs_p_q <= cs_n;
			sck_p_q <= sclk;
		end
	end
	AST_OE_ON: assert property (
		$fell(cs_n) |-> ##2 !sdata_oe ##1 (sdata_oe && !sdata_o))
		else $error("Data line not taken up after select fall");
	AST_NULLS: assert property (
		$fell(cs_n) |-> ##3 (!sdata throughout (1'b1 ##55 1'b1)))
		else $error("Null bits not low");
	AST_DOUT_FALL: assert property (
		(sdata_oe && $past(sdata_oe) && !cs_n && $changed(sdata_o))
		|-> ($past(sclk, 4) && !$past(sclk, 3)))
		else $error("Data changed away from a clock fall");
	AST_DOUT_STEADY: assert property (
		$rose(sclk) |-> $stable(sdata) [*8])
		else $error("Data moved while clock high");
	AST_SCLK_HIGH: assert property (
		$rose(sclk) |-> sclk [*7] ##1 !sclk)
		else $error("Clock high time wrong");
	AST_SCLK_LOW: assert property (
		$fell(sclk) |-> (!sclk) [*7])
		else $error("Clock low time short");
	AST_SCLK_IDLE: assert property (
		cs_n |-> !sclk)
		else $error("Clock moved outside a frame");
	AST_LOW_TIME: assert property (
		$rose(cs_n) |-> lo_q == 16'd231)
		else $error("Select low time wrong");
	AST_SIXTEEN: assert property (
		$rose(cs_n) |-> ris_q == 5'd16)
		else $error("Frame did not hold sixteen clocks");
	AST_SPACING: assert property (
		($fell(cs_n) && seen_q) |-> gap_q >= FRAME_CYC)
		else $error("Frames too close");
	AST_OE_OFF: assert property (
		$rose(cs_n) |-> ##2 sdata_oe ##1 !sdata_oe)
		else $error("Data line kept after select rise");
endmodule

// ===== testbench.sv
// Self-checking bench: both ends on one link, a bare converter end on
// a second link driven by the bench. Assumes all ends share one clock.
`timescale 1ns/1ns
module testbench import adc_link_pkg::*;;
	logic        clock = 1'b0;  // Local clock
	logic        rstn = 1'b0;   // Sync reset
	logic        run = 1'b0;    // Allow frames
	logic        ce = 1'b1;     // Clock enable shared by all ends
	logic        rd_ready = 1'b0;
	logic        stall = 1'b0;  // Consumer refuses all words
	logic [11:0] vin_p = 12'h0;
	logic [11:0] vin_n = 12'h0;
	logic        rd_valid, frame_active, pd_a, busy_a, pd_b, busy_b;
	logic [11:0] rd_data;
	logic [15:0] wbits = 16'h0;  // Bits seen on the main wire
	int          nbits = 0;
	logic [11:0] q_rd[$], q_w[$]; // Words still expected
	int          err_count = 0, n_tests = 0;
	localparam logic [23:0] CORN [4] = '{24'hfff000, 24'h000fff,
		24'h800800, 24'h000001};
	adc_link_if link();
	adc_link_if link_b();
	adc_sample_device i_adc_sample_device (.clock(clock), .rstn(rstn),
		.ce(ce), .link(link.device), .vin_p(vin_p), .vin_n(vin_n),
		.power_down(pd_a), .busy(busy_a));
	adc_sample_device i_adc_sample_device_b (.clock(clock), .rstn(rstn),
		.ce(ce), .link(link_b.device), .vin_p(vin_p), .vin_n(vin_n),
		.power_down(pd_b), .busy(busy_b));
	adc_sample_host #(.HALF_CYC(7), .FRAME_CYC(250)) i_adc_sample_host (
		.clock(clock), .rstn(rstn), .ce(ce), .run(run),
		.frame_active(frame_active), .link(link.host),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	adc_link_monitor #(.FRAME_CYC(250)) i_adc_link_monitor (
		.clock(clock), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
		.sdata_o(link.sdata_o), .sdata_oe(link.sdata_oe),
		.sdata(link.sdata));
	always #10 clock = ~clock;
	// Halved 13-bit difference, kept as 12-bit two's complement
	function automatic logic [11:0] exp_code(input logic [11:0] p,
		input logic [11:0] n);
		logic [12:0] d;
		d = {1'b0, p} - {1'b0, n};
		return d[12:1];
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Checks: %0d, mismatches: %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Bounded wait on frame activity; a stuck host counts as a fault
	task automatic wait_fa(input logic v);
		int k;
		for (k = 0; k < 4000 && frame_active !== v; k++) @(negedge clock);
		check(16'(k >= 4000), 16'h0);
	endtask
	// One frame on the second link at 160 ns, off the local clock grid
	task automatic drive_b(input int n, output logic [15:0] w);
		w = 16'h0;
		#7 link_b.cs_n = 1'b0;
		repeat (n) begin
			#80 link_b.sclk = 1'b1;
			w = {w[14:0], link_b.sdata};
			#80 link_b.sclk = 1'b0;
		end
		#80 link_b.cs_n = 1'b1;
	endtask
	// Each select fall owes one word, read from the input held then
	always @(negedge link.cs_n) begin
		q_rd.push_back(exp_code(vin_p, vin_n));
		q_w.push_back(exp_code(vin_p, vin_n));
	end
	// Host sampling point: gather the frame from the wire
	always @(posedge link.sclk) begin
		wbits = {wbits[14:0], link.sdata};
		nbits++;
	end
	always @(posedge link.cs_n) begin
		if (nbits != 0) begin
			check(16'(nbits), 16'd16);
			check(wbits, {4'h0, q_w.pop_front()});
			nbits = 0;
		end
	end
	// Random consumer; words are checked at the popping edge
	always @(negedge clock) begin
		rd_ready <= stall ? 1'b0 : 1'($urandom);
	end
	always @(posedge clock) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			check({4'h0, rd_data}, {4'h0, q_rd.pop_front()});
		end
	end
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		int i;
		logic [15:0] w;
		logic [11:0] e;
		void'($urandom(81135));
		link_b.cs_n = 1'b1;
		link_b.sclk = 1'b0;
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		run = 1'b1;
		check({14'h0, pd_a, busy_a}, 16'h2);
		// Corner inputs first, then random; inputs move between frames
		for (i = 0; i < 16; i++) begin
			wait_fa(1'b0);
			{vin_p, vin_n} = (i < 4) ? CORN[i] : 24'($urandom);
			wait_fa(1'b1);
			repeat (10) @(negedge clock);
			check({14'h0, pd_a, busy_a}, 16'h1);
		end
		// Full buffer stops frames and loses nothing
		stall = 1'b1;
		repeat (1500) @(negedge clock);
		check({15'h0, frame_active}, 16'h0);
		check(16'(q_rd.size()), 16'h2);
		stall = 1'b0;
		repeat (1500) @(negedge clock);
		run = 1'b0;
		wait_fa(1'b0);
		repeat (600) @(negedge clock);
		check({13'h0, link.cs_n, pd_a, busy_a}, 16'h6);
		check(16'(q_rd.size()), 16'h0);
		// Enable low freezes both ends: no frame starts, no reply
		{vin_p, vin_n} = 24'h7ff000;
		ce  = 1'b0;
		run = 1'b1;
		drive_b(16, w);
		#100;
		check({14'h0, link.cs_n, frame_active}, 16'h2);
		check({14'h0, link_b.sdata_oe, pd_b}, 16'h1);
		check(w, 16'h0);
		@(negedge clock);
		run = 1'b0;
		ce  = 1'b1;
		// Second link: whole frame, aborted frame, whole frame again
		for (i = 0; i < 3; i++) begin
			// Inputs move on the falling edge only
			@(negedge clock);
			{vin_p, vin_n} = 24'($urandom);
			e = exp_code(vin_p, vin_n);
			drive_b((i == 1) ? 6 : 16, w);
			#100;
			check({14'h0, link_b.sdata_oe, pd_b}, 16'h1);
			check(w, (i == 1) ? 16'({4'h0, e} >> 10) : {4'h0, e});
		end
		wrap_up();
	end
endmodule
